/* shared/spihc_pkg.sv */
// What this block does
// R01: Bit order control picks MSB or LSB first
// R02: Host-select bit: 0 client, 1 host
// R03: Select low in host clears host, sets done
// R04: Clock-double doubles host serial clock rate
// R05: Divider field gives clock/4, /16, /64, /128
// R06: Interface works only while enable is set
// R07: Buffer mode: two receive, one transmit stage
// R08: Wait-receive 0: first byte is dummy
// R09: Wait-receive 1: first write loads shifter directly
// R10: Select-disable makes host ignore select line
// R11: Mode field sets clock phase and polarity
// R12: Serial clock idles at mode polarity level
// R13: Buffer-mode enables gate flags, else read zero
// R14: Normal mode: enable bit gates done flag
// R15: Done flag set when byte fully shifted
// R16: Done flag also set by select-low in host
// R17: Done cleared by write one or read-then-data
// R18: Collision flag set on write while shifting
// R19: Collision cleared only by read-then-data access
// R20: Interrupt holds while enable and flag set
// R21: Data address maps to shifter or buffers
// R22: Client select high resets transfer, data lost
// R23: Flag register layout follows buffer mode
package spihc_pkg;
	localparam logic [2:0] CTRL_A_IDX = 3'h0;
	localparam logic [2:0] CTRL_B_IDX = 3'h1;
	localparam logic [2:0] IRQ_EN_IDX = 3'h2;
	localparam logic [2:0] FLAG_IDX   = 3'h3;
	localparam logic [2:0] DATA_IDX   = 3'h4;
	localparam int CA_LSBF = 6;
	localparam int CA_HOST = 5;
	localparam int CA_X2   = 4;
	localparam int CA_DIV  = 1;
	localparam int CA_EN   = 0;
	localparam int CB_BUF  = 7;
	localparam int CB_BWR  = 6;
	localparam int CB_SSD  = 2;
	localparam int CB_MODE = 0;
	localparam int IE_NORM = 0;
	localparam int FN_DONE = 7;
	localparam int FN_COL  = 6;
	localparam logic [7:0] CA_MASK   = 8'h77;
	localparam logic [7:0] CB_MASK   = 8'hC7;
	localparam logic [7:0] IE_MASK   = 8'hF1;
	localparam logic [7:0] IE_NMASK  = 8'h01;
	localparam logic [7:0] REG_RST   = 8'h00;
	localparam logic [7:0] DUMMY_B   = 8'h00;
	localparam logic [3:0] SYNC_RST  = 4'h8;
	localparam logic [1:0] RX_DEPTH  = 2'h2;
	localparam logic [4:0] LAST_EDGE = 5'h0F;
	localparam int P_SCK  = 0;
	localparam int P_MOSI = 1;
	localparam int P_MISO = 2;
	localparam int P_SS   = 3;
	localparam logic [7:0] SCK_DIV0 = 8'h04;
	localparam logic [7:0] SCK_DIV1 = 8'h10;
	localparam logic [7:0] SCK_DIV2 = 8'h40;
	localparam logic [7:0] SCK_DIV3 = 8'h80;
	typedef enum logic [0:0] {SPIHC_IDLE = 1'b0, SPIHC_RUN = 1'b1} spihc_eng_t;

	// Cycles per serial clock half period, minus one
	function automatic logic [6:0] half_m1(input logic [1:0] dv, input logic x2);
		logic [7:0] d;
		logic [7:0] h;
		case (dv)
			2'h0: d = SCK_DIV0;
			2'h1: d = SCK_DIV1;
			2'h2: d = SCK_DIV2;
			default: d = SCK_DIV3;
		endcase
		h = x2 ? (d >> 2) : (d >> 1);
		return h[6:0] - 7'h01;
	endfunction
endpackage

/* shared/spihc_shift_if.sv */
interface spihc_shift_if;
	logic       en;
	logic       host;
	logic       lsbf;
	logic       sck_double;
	logic [1:0] mode;
	logic [1:0] sck_divider;
	logic       start;
	logic       abort;
	logic [7:0] txd;
	logic       sck_v;
	logic       mosi_v;
	logic       miso_v;
	logic       ss_v;
	logic       busy;
	logic       done;
	logic [7:0] rxd;
	logic       sck_o;
	logic       sdo;
	modport ctl (output en, host, lsbf, sck_double, mode, sck_divider, start, abort, txd, sck_v, mosi_v, miso_v, ss_v,
		input busy, done, rxd, sck_o, sdo);
	modport eng (input en, host, lsbf, sck_double, mode, sck_divider, start, abort, txd, sck_v, mosi_v, miso_v, ss_v,
		output busy, done, rxd, sck_o, sdo);
endinterface

/* rtl/spihc_engine.sv */
module spihc_engine
	import spihc_pkg::*;
(
	// Clock and reset
	input wire logic   clk_sys_in,
	input wire logic   rst_n_in,
	input wire logic   ce_in,
	// Control side
	spihc_shift_if.eng sh
);
	spihc_eng_t st_q;
	spihc_eng_t st_d;
	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic [4:0] edg_q;
	logic [4:0] edg_d;
	logic [7:0] sr_q;
	logic [7:0] sr_d;
	logic [7:0] rx_q;
	logic [7:0] rx_d;
	logic       ph_q;
	logic       ph_d;
	logic       have_q;
	logic       have_d;
	logic       bit_q;
	logic       bit_d;
	logic       done_q;
	logic       done_d;
	logic       psck_q;
	logic       tick;
	logic       samp;
	logic       nb;

	function automatic logic [7:0] shf(input logic [7:0] s, input logic b, input logic lsbf);
		return lsbf ? {b, s[7:1]} : {s[6:0], b};
	endfunction

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		edg_d  = edg_q;
		sr_d   = sr_q;
		rx_d   = rx_q;
		ph_d   = ph_q;
		have_d = have_q;
		bit_d  = bit_q;
		done_d = 1'b0;
		tick   = sh.host ? (st_q == SPIHC_RUN && cnt_q == 7'h00) : (!sh.ss_v && sh.sck_v != psck_q);
		samp   = (edg_q[0] == sh.mode[0]); // R11
		nb     = sh.host ? sh.miso_v : sh.mosi_v;
		if (st_q == SPIHC_RUN && cnt_q != 7'h00)
			cnt_d = cnt_q - 7'h01;
		if (tick) begin
			cnt_d = half_m1(sh.sck_divider, sh.sck_double); // R04 R05
			ph_d  = ~ph_q;
			st_d  = SPIHC_RUN;
			edg_d = edg_q + 5'h01;
			if (samp) begin
				bit_d  = nb;
				have_d = 1'b1;
			end
			if (!samp && have_q) begin
				sr_d   = shf(sr_q, bit_q, sh.lsbf); // R01
				have_d = 1'b0;
			end
			if (edg_q == LAST_EDGE) begin
				st_d   = SPIHC_IDLE;
				edg_d  = 5'h00;
				have_d = 1'b0;
				ph_d   = 1'b0;
				done_d = 1'b1; // R15
				// A final sampling edge has no setup edge after it; its bit goes to the result only,
				// so the data pin does not move on the edge at which the far side samples it
				rx_d   = samp ? shf(sr_q, nb, sh.lsbf) : sr_d; // R01
			end
		end
		if (sh.abort) begin
			st_d   = SPIHC_IDLE; // R22
			edg_d  = 5'h00;
			have_d = 1'b0;
			ph_d   = 1'b0;
			cnt_d  = 7'h00;
			done_d = 1'b0;
		end
		if (sh.start) begin
			sr_d   = sh.txd;
			cnt_d  = half_m1(sh.sck_divider, sh.sck_double);
			st_d   = sh.host ? SPIHC_RUN : SPIHC_IDLE;
			edg_d  = 5'h00;
			ph_d   = 1'b0;
			have_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q   <= SPIHC_IDLE;
			cnt_q  <= 7'h00;
			edg_q  <= 5'h00;
			sr_q   <= 8'h00;
			rx_q   <= 8'h00;
			ph_q   <= 1'b0;
			have_q <= 1'b0;
			bit_q  <= 1'b0;
			done_q <= 1'b0;
			psck_q <= 1'b0;
		end else if (ce_in) begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			edg_q  <= edg_d;
			sr_q   <= sr_d;
			rx_q   <= rx_d;
			ph_q   <= ph_d;
			have_q <= have_d;
			bit_q  <= bit_d;
			done_q <= done_d;
			psck_q <= sh.sck_v;
		end
	end

	assign sh.busy  = (st_q == SPIHC_RUN);
	assign sh.done  = done_q;
	assign sh.rxd   = rx_q;
	assign sh.sck_o = sh.mode[1] ^ ph_q; // R12
	assign sh.sdo   = sh.lsbf ? sr_q[0] : sr_q[7]; // R01
endmodule

/* rtl/spihc_top.sv */
// Added by the designer: the AHB-Lite interface to the registers.
module spihc_top
	import spihc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output wire logic        hreadyout_out,
	output wire logic        hresp_out,
	output wire logic [31:0] hrdata_out,
	// Serial pins
	input  wire logic        sck_in,
	output wire logic        sck_out,
	output wire logic        sck_oe_out,
	input  wire logic        mosi_in,
	output wire logic        mosi_out,
	output wire logic        mosi_oe_out,
	input  wire logic        miso_in,
	output wire logic        miso_out,
	output wire logic        miso_oe_out,
	input  wire logic        ss_n_in,
	// Interrupt request
	output wire logic        irq_out
);
	spihc_shift_if sh ();

	logic [3:0]  s1_q;
	logic [3:0]  s1_d;
	logic [3:0]  s2_q;
	logic [3:0]  s2_d;
	logic [3:0]  s3_q;
	logic [3:0]  s3_d;
	logic [3:0]  pin_q;
	logic [3:0]  pin_d;
	logic [3:0]  agree;

	logic        dp_q;
	logic        dp_d;
	logic [2:0]  dpi_q;
	logic [2:0]  dpi_d;
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;
	logic [7:0]  ctla_q;
	logic [7:0]  ctla_d;
	logic [7:0]  ctlb_q;
	logic [7:0]  ctlb_d;
	logic [7:0]  ien_q;
	logic [7:0]  ien_d;
	logic        done_f_q;
	logic        done_f_d;
	logic        col_q;
	logic        col_d;
	logic        arm_done_q;
	logic        arm_done_d;
	logic        arm_col_q;
	logic        arm_col_d;
	logic        txc_q;
	logic        txc_d;
	logic        ssf_q;
	logic        ssf_d;
	logic        ovf_q;
	logic        ovf_d;
	logic [7:0]  txb_q;
	logic [7:0]  txb_d;
	logic        txf_q;
	logic        txf_d;
	logic [7:0]  rxb_q [2];
	logic [7:0]  rxb_d [2];
	logic [1:0]  rxn_q;
	logic [1:0]  rxn_d;
	logic [7:0]  rxd_q;
	logic [7:0]  rxd_d;
	logic        full_q;
	logic        full_d;
	logic        primed_q;
	logic        primed_d;

	logic        ap;
	logic        amap;
	logic [2:0]  aidx;
	logic        rd;
	logic        rd_flag;
	logic        rd_data;
	logic        wr_a;
	logic        wr_b;
	logic        wr_ie;
	logic        wr_flag;
	logic        wr_data;
	logic [7:0]  wd;
	logic [7:0]  rv;
	logic        buffered_operation_enable;
	logic        en;
	logic        host;
	logic        ss_hi;
	logic        hostdrop;
	logic        go;
	logic [7:0]  go_txd;
	logic [7:0]  flags_v;

	// Pin synchronisers; a change is taken once the last two stages agree
	always_comb begin
		s1_d  = {ss_n_in, miso_in, mosi_in, sck_in};
		s2_d  = s1_q;
		s3_d  = s2_q;
		agree = s2_q ~^ s3_q;
		pin_d = (pin_q & ~agree) | (s3_q & agree);
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_q  <= SYNC_RST;
			s2_q  <= SYNC_RST;
			s3_q  <= SYNC_RST;
			pin_q <= SYNC_RST;
		end else if (ce_in) begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			s3_q  <= s3_d;
			pin_q <= pin_d;
		end
	end

	// Bus decode, registers and flags
	always_comb begin
		dp_d       = 1'b0;
		dpi_d      = dpi_q;
		hrdata_d   = 32'h0000_0000;
		ctla_d     = ctla_q;
		ctlb_d     = ctlb_q;
		ien_d      = ien_q;
		done_f_d   = done_f_q;
		col_d      = col_q;
		arm_done_d = arm_done_q;
		arm_col_d  = arm_col_q;
		txc_d      = txc_q;
		ssf_d      = ssf_q;
		ovf_d      = ovf_q;
		txb_d      = txb_q;
		txf_d      = txf_q;
		rxb_d      = rxb_q;
		rxn_d      = rxn_q;
		rxd_d      = rxd_q;
		full_d     = full_q;
		primed_d   = primed_q;
		go         = 1'b0;
		buffered_operation_enable      = ctlb_q[CB_BUF];
		en         = ctla_q[CA_EN];
		host       = ctla_q[CA_HOST];
		ss_hi      = pin_q[P_SS];
		wd         = hwdata_in[7:0];
		go_txd     = wd;

		// Address phase: reads are answered and take their side effects here
		ap      = hsel_in & htrans_in[1] & hready_in;
		aidx    = haddr_in[4:2];
		amap    = (haddr_in[31:5] == 27'h0) && (aidx <= DATA_IDX);
		rd      = ap & ~hwrite_in & amap;
		rd_flag = rd && aidx == FLAG_IDX;
		rd_data = rd && aidx == DATA_IDX;
		if (ap && hwrite_in && amap) begin
			dp_d  = 1'b1;
			dpi_d = aidx;
		end
		wr_a    = dp_q && dpi_q == CTRL_A_IDX;
		wr_b    = dp_q && dpi_q == CTRL_B_IDX;
		wr_ie   = dp_q && dpi_q == IRQ_EN_IDX;
		wr_flag = dp_q && dpi_q == FLAG_IDX;
		wr_data = dp_q && dpi_q == DATA_IDX;

		flags_v = buffered_operation_enable ? {rxn_q != 2'h0, txc_q, ~txf_q, ssf_q, 3'h0, ovf_q}
			: {done_f_q, col_q, 6'h00}; // R23
		case (aidx)
			CTRL_A_IDX: rv = ctla_q;
			CTRL_B_IDX: rv = ctlb_q;
			IRQ_EN_IDX: rv = ien_q & (buffered_operation_enable ? IE_MASK : IE_NMASK); // R13
			FLAG_IDX:   rv = flags_v;
			DATA_IDX:   rv = buffered_operation_enable ? rxb_q[0] : rxd_q; // R21
			default:    rv = 8'h00;
		endcase
		if (rd)
			hrdata_d = {24'h00_0000, rv};

		if (wr_a)
			ctla_d = wd & CA_MASK; // R02 R06
		if (wr_b)
			ctlb_d = wd & CB_MASK;
		if (wr_ie)
			ien_d = wd & IE_MASK;

		// Write-one-to-clear; any set below in the same cycle wins
		if (wr_flag) begin
			if (!buffered_operation_enable && wd[FN_DONE])
				done_f_d = 1'b0; // R17
			if (buffered_operation_enable) begin
				if (wd[7])
					rxn_d = 2'h0;
				if (wd[6])
					txc_d = 1'b0;
				if (wd[4])
					ssf_d = 1'b0;
				if (wd[0])
					ovf_d = 1'b0;
			end
		end

		// Flag read arms the clear; the next data access completes it
		if ((rd_data || wr_data) && !buffered_operation_enable) begin
			if (arm_done_q)
				done_f_d = 1'b0; // R17
			if (arm_col_q)
				col_d = 1'b0; // R19
			arm_done_d = 1'b0;
			arm_col_d  = 1'b0;
		end
		if (rd_flag && !buffered_operation_enable) begin
			arm_done_d = done_f_q;
			arm_col_d  = col_q;
		end

		// Data writes
		if (wr_data) begin
			if (!buffered_operation_enable) begin
				if (sh.busy)
					col_d = 1'b1; // R18
				else
					go = 1'b1; // R21
			end else if (!txf_q) begin
				txb_d = wd; // R07 R21
				txf_d = 1'b1;
			end
		end

		// Receive buffer pop on a data read
		if (rd_data && buffered_operation_enable) begin
			ovf_d = 1'b0;
			if (rxn_q != 2'h0) begin
				rxb_d[0] = rxb_q[1];
				rxn_d    = rxn_q - 2'h1;
			end
		end

		// End of a byte
		if (sh.done) begin
			full_d   = 1'b0;
			primed_d = 1'b1;
			if (!buffered_operation_enable) begin
				done_f_d = 1'b1; // R15
				rxd_d    = sh.rxd;
			end else begin
				if (rxn_d < RX_DEPTH) begin
					rxb_d[rxn_d[0]] = sh.rxd; // R07
					rxn_d           = rxn_d + 2'h1;
				end else begin
					ovf_d = 1'b1;
				end
				if (!txf_q)
					txc_d = 1'b1;
			end
		end

		// Move the transmit buffer into the shifter once it is free
		if (buffered_operation_enable && en && txf_q && !full_q && !sh.busy) begin
			if (primed_q || (ctlb_q[CB_BWR] && ss_hi)) begin
				go     = 1'b1; // R09
				go_txd = txb_q;
				txf_d  = 1'b0;
			end else if (host && !ctlb_q[CB_BWR]) begin
				// A host must clock a dummy byte before the buffered one can go
				go     = 1'b1; // R08
				go_txd = DUMMY_B;
			end
		end
		if (go)
			full_d = 1'b1;

		// Select pulled low while hosting hands the bus over
		hostdrop = en & host & ~ctlb_q[CB_SSD] & ~ss_hi; // R10
		if (hostdrop) begin
			ctla_d[CA_HOST] = 1'b0; // R03
			if (buffered_operation_enable)
				ssf_d = 1'b1;
			else
				done_f_d = 1'b1; // R16
		end

		// Without enable the shifter holds nothing the buffer must wait for
		if (!en) begin
			full_d   = 1'b0; // R06
			primed_d = 1'b0;
		end
		if (!buffered_operation_enable)
			primed_d = 1'b0;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dp_q       <= 1'b0;
			dpi_q      <= 3'h0;
			hrdata_q   <= 32'h0000_0000;
			ctla_q     <= REG_RST;
			ctlb_q     <= REG_RST;
			ien_q      <= REG_RST;
			done_f_q   <= 1'b0;
			col_q      <= 1'b0;
			arm_done_q <= 1'b0;
			arm_col_q  <= 1'b0;
			txc_q      <= 1'b0;
			ssf_q      <= 1'b0;
			ovf_q      <= 1'b0;
			txb_q      <= REG_RST;
			txf_q      <= 1'b0;
			rxb_q[0]   <= REG_RST;
			rxb_q[1]   <= REG_RST;
			rxn_q      <= 2'h0;
			rxd_q      <= REG_RST;
			full_q     <= 1'b0;
			primed_q   <= 1'b0;
		end else if (ce_in) begin
			dp_q       <= dp_d;
			dpi_q      <= dpi_d;
			hrdata_q   <= hrdata_d;
			ctla_q     <= ctla_d;
			ctlb_q     <= ctlb_d;
			ien_q      <= ien_d;
			done_f_q   <= done_f_d;
			col_q      <= col_d;
			arm_done_q <= arm_done_d;
			arm_col_q  <= arm_col_d;
			txc_q      <= txc_d;
			ssf_q      <= ssf_d;
			ovf_q      <= ovf_d;
			txb_q      <= txb_d;
			txf_q      <= txf_d;
			rxb_q      <= rxb_d;
			rxn_q      <= rxn_d;
			rxd_q      <= rxd_d;
			full_q     <= full_d;
			primed_q   <= primed_d;
		end
	end

	// Shift engine hookup
	assign sh.en     = en;
	assign sh.host   = host;
	assign sh.lsbf   = ctla_q[CA_LSBF];
	assign sh.sck_double  = ctla_q[CA_X2];
	assign sh.sck_divider  = ctla_q[CA_DIV +: 2];
	assign sh.mode   = ctlb_q[CB_MODE +: 2];
	assign sh.start  = go;
	assign sh.txd    = go_txd;
	assign sh.abort  = ~en | hostdrop | (~host & ss_hi); // R06 R22
	assign sh.sck_v  = pin_q[P_SCK];
	assign sh.mosi_v = pin_q[P_MOSI];
	assign sh.miso_v = pin_q[P_MISO];
	assign sh.ss_v   = ss_hi;

	spihc_engine u_engine (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.ce_in      (ce_in),
		.sh         (sh)
	);

	// Pins: host drives clock and data out, a selected client drives its reply
	assign sck_out     = sh.sck_o;
	assign sck_oe_out  = en & host; // R02 R12
	assign mosi_out    = sh.sdo;
	assign mosi_oe_out = en & host;
	assign miso_out    = sh.sdo;
	assign miso_oe_out = en & ~host & ~ss_hi;

	// Stalling the bus while frozen keeps the master from losing a transfer
	assign hreadyout_out = ce_in;
	assign hresp_out     = 1'b0;
	assign hrdata_out    = hrdata_q;

	assign irq_out = buffered_operation_enable ? |(flags_v[7:4] & ien_q[7:4]) // R13 R20
		: (ien_q[IE_NORM] & done_f_q); // R14 R20
endmodule

/* verif/spihc_assertions.sv */
module spihc_assertions
	import spihc_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys_in,
	input wire logic        rst_n_in,
	input wire logic        ce_in,
	// Bus
	input wire logic        hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic [31:0] hwdata_in,
	// Serial and interrupt
	input wire logic        sck_out,
	input wire logic        sck_oe_out,
	input wire logic        miso_oe_out,
	input wire logic        ss_n_in,
	input wire logic        irq_out
);
	// Shadows of software writes let clock timing be judged from the ports alone
	logic       wp_q;
	logic [4:0] wa_q;
	logic [7:0] ca_q;
	logic [7:0] cb_q;
	logic [7:0] ie_q;
	logic       sp_q;
	logic [7:0] cnt_q;
	logic [4:0] ec_q;
	logic [7:0] half;
	logic       chg;
	assign chg = sck_out != sp_q;
	assign half = ((ca_q[2:1] == 2'h3) ? 8'h80 : (8'h04 << {ca_q[2:1], 1'b0})) >> (ca_q[4] ? 2 : 1);
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wp_q <= 1'b0;
			wa_q <= 5'h00;
			ca_q <= 8'h00;
			cb_q <= 8'h00;
			ie_q <= 8'h00;
			sp_q <= 1'b0;
			cnt_q <= 8'h00;
			ec_q <= 5'h10;
		end else begin
			wp_q <= hsel_in && htrans_in[1] && hwrite_in && ce_in;
			wa_q <= haddr_in[4:0];
			if (wp_q && wa_q == 5'h00) ca_q <= hwdata_in[7:0];
			if (wp_q && wa_q == 5'h04) cb_q <= hwdata_in[7:0];
			if (wp_q && wa_q == 5'h08) ie_q <= hwdata_in[7:0];
			sp_q <= sck_out;
			cnt_q <= chg ? 8'h01 : (cnt_q == 8'hFF ? cnt_q : cnt_q + 8'h01);
			// First edge of a byte follows an idle gap of any length, so it is not timed
			if (wp_q && wa_q == 5'h10) ec_q <= 5'h00;
			else if (chg && ec_q != 5'h1F) ec_q <= ec_q + 5'h01;
		end
	end
	default clocking dc @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	oe_role_a: assert property (sck_oe_out |-> (ca_q[0] && ca_q[5]) || $past(ca_q[0] && ca_q[5]))
		else $error("serial clock driven outside enabled host role");
	role_excl_a: assert property (miso_oe_out |-> !sck_oe_out)
		else $error("host and client outputs enabled together");
	idle_lvl_a: assert property ($rose(sck_oe_out) |-> sck_out == cb_q[1])
		else $error("serial clock not at idle level when driven");
	half_per_a: assert property (chg && sck_oe_out && ec_q != 5'h00 && ec_q < 5'h10 |-> cnt_q == half)
		else $error("serial clock half period wrong");
	irq_gate_a: assert property (irq_out |-> ie_q != 8'h00 || $past(ie_q != 8'h00))
		else $error("interrupt with all enables clear");
	ss_drop_a: assert property ($fell(ss_n_in) && sck_oe_out && !cb_q[2] ##1 (!ss_n_in)[*4] |-> ##[0:4] !sck_oe_out)
		else $error("host role kept while selected");
	ssd_hold_a: assert property (sck_oe_out && cb_q[2] && !ss_n_in && !wp_q |=> sck_oe_out)
		else $error("host role lost with select disabled");
	client_rel_a: assert property ($rose(ss_n_in) |-> ##[1:6] !miso_oe_out)
		else $error("client output kept after deselect");
endmodule

bind spihc_top spihc_assertions u_chk (.clk_sys_in, .rst_n_in, .ce_in, .hsel_in, .haddr_in, .htrans_in,
	.hwrite_in, .hwdata_in, .sck_out, .sck_oe_out, .miso_oe_out, .ss_n_in, .irq_out);

/* verif/spihc_partner.sv */
module spihc_partner (
	// Serial lines
	input  wire logic       sck_in,
	input  wire logic       mosi_in,
	input  wire logic       ss_n_in,
	// Setup
	input  wire logic [1:0] mode_in,
	input  wire logic       lsbf_in,
	input  wire logic [7:0] tx_in,
	// Results
	output logic            miso_out,
	output logic [7:0]      rx_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int nb;
	function automatic logic pick(input int i);
		return lsbf_in ? tx_in[i] : tx_in[7 - i];
	endfunction
	initial begin
		miso_out = 1'b0;
		rx_out = 8'h00;
		nb = 0;
	end
	always @(negedge ss_n_in) begin
		nb = 0;
		if (!mode_in[0]) miso_out = pick(0);
	end
	// A released line must not keep showing its last bit
	always @(posedge ss_n_in) miso_out = ~miso_out;
	always @(sck_in) begin
		if (!ss_n_in && (sck_in ^ mode_in[1] ^ mode_in[0])) begin
			rx_out = lsbf_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
			nb++;
		end else if (!ss_n_in && nb < 8) begin
			miso_out = pick(nb);
		end
	end
endmodule

/* verif/test_spi_host_client_control.sv */
module test_spi_host_client_control
	import spihc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] A_CA = {CTRL_A_IDX, 2'b00};
	localparam logic [4:0] A_CB = {CTRL_B_IDX, 2'b00};
	localparam logic [4:0] A_IE = {IRQ_EN_IDX, 2'b00};
	localparam logic [4:0] A_FL = {FLAG_IDX, 2'b00};
	localparam logic [4:0] A_DT = {DATA_IDX, 2'b00};
	logic        clk_sys_in, rst_n_in, ce_in, hsel_in, hwrite_in, ss_n_in;
	logic [31:0] haddr_in, hwdata_in, hrdata_out;
	logic [1:0]  htrans_in, pmode;
	logic        hreadyout_out, sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, irq_out;
	logic        psel_n, tb_sck, tb_mosi, plsb, p_miso, hresp_out;
	logic [7:0]  ptx, prx, rv;
	int          num_errors, checks, wn;
	wire         sck_in = sck_oe_out ? sck_out : tb_sck;
	wire         mosi_in = mosi_oe_out ? mosi_out : tb_mosi;
	wire         miso_in = miso_oe_out ? miso_out : p_miso;
	spihc_top uut (.clk_sys_in, .rst_n_in, .ce_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
		.hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out, .hresp_out, .hrdata_out,
		.sck_in, .sck_out, .sck_oe_out, .mosi_in, .mosi_out, .mosi_oe_out, .miso_in, .miso_out, .miso_oe_out,
		.ss_n_in, .irq_out);
	spihc_partner far (.sck_in(sck_in), .mosi_in(mosi_in), .ss_n_in(psel_n), .mode_in(pmode), .lsbf_in(plsb),
		.tx_in(ptx), .miso_out(p_miso), .rx_out(prx));
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	task automatic stop_test;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		hsel_in <= 1'b1;
		haddr_in <= {27'h0, a};
		htrans_in <= 2'h2;
		hwrite_in <= w;
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
		htrans_in <= 2'h0;
		hwdata_in <= {24'h0, d};
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
		rv = hrdata_out[7:0];
		chk({7'h0, hresp_out}, 8'h00);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rv, e);
	endtask
	task automatic wirq(input int lim);
		wn = 0;
		while (irq_out !== 1'b1 && wn < lim) begin
			@(posedge clk_sys_in);
			wn++;
		end
		chk({7'h0, irq_out}, 8'h01);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 6; i++) rdc(5'(i * 4), REG_RST);
		wr(A_CA, 8'hFF);
		rdc(A_CA, CA_MASK);
		wr(A_CA, 8'h00);
		wr(A_CB, 8'hFF);
		rdc(A_CB, CB_MASK);
		wr(A_IE, 8'hFF);
		rdc(A_IE, IE_MASK);
		wr(A_CB, 8'h00);
		rdc(A_IE, IE_NMASK);
		wr(5'h14, 8'hFF);
		rdc(5'h14, 8'h00);
		wr(A_IE, 8'h01);
	endtask
	task automatic t_host(input logic [1:0] m, input logic lsb);
		pmode = m;
		plsb = lsb;
		ptx = 8'h5A ^ {4'h0, m, lsb, 1'b0};
		wr(A_CB, {6'h00, m});
		wr(A_CA, {1'b0, lsb, 6'h23});
		repeat (4) @(posedge clk_sys_in);
		psel_n <= 1'b0;
		wr(A_DT, 8'hC3 ^ ptx);
		wirq(400);
		psel_n <= 1'b1;
		chk(prx, 8'hC3 ^ ptx);
		if (lsb) wr(A_FL, 8'h80);
		else rdc(A_FL, 8'h80);
		rdc(A_DT, ptx);
		rdc(A_FL, 8'h00);
		chk({7'h0, irq_out}, 8'h00);
		wr(A_CA, 8'h00);
	endtask
	task automatic t_coll;
		pmode = 2'h0;
		plsb = 1'b0;
		ptx = 8'h96;
		wr(A_CB, 8'h00);
		wr(A_CA, 8'h23);
		repeat (4) @(posedge clk_sys_in);
		psel_n <= 1'b0;
		wr(A_DT, 8'h3C);
		wr(A_DT, 8'hF0);
		wirq(400);
		psel_n <= 1'b1;
		chk(prx, 8'h3C);
		rdc(A_FL, 8'hC0);
		rdc(A_DT, 8'h96);
		rdc(A_FL, 8'h00);
	endtask
	task automatic t_buf;
		pmode = 2'h0;
		plsb = 1'b0;
		ptx = 8'hA5;
		wr(A_CB, 8'hC0);
		wr(A_CA, 8'h23);
		psel_n <= 1'b0;
		wr(A_DT, 8'h69);
		repeat (200) @(posedge clk_sys_in);
		psel_n <= 1'b1;
		chk(prx, 8'h69);
		rdc(A_FL, 8'hE0);
		rdc(A_DT, 8'hA5);
		rdc(A_FL, 8'h60);
		wr(A_CB, 8'h00);
		wr(A_CA, 8'h00);
	endtask
	task automatic t_div;
		int h;
		for (int dv = 0; dv < 4; dv++) begin
			for (int x = 0; x < 2; x++) begin
				h = (dv == 3 ? 128 : 4 << (2 * dv)) >> (x ? 2 : 1);
				wr(A_CA, {2'b00, 1'b1, x[0], 1'b0, dv[1:0], 1'b1});
				wr(A_DT, 8'h55);
				wirq(3000);
				checks++;
				if (wn < 15 * h || wn > 17 * h + 8) begin
					num_errors++;
					$display("[ERR] %0t got %h exp %h", $time, wn, 16 * h);
				end
				wr(A_FL, 8'h80);
			end
		end
	endtask
	task automatic t_ss;
		wr(A_CB, 8'h04);
		wr(A_CA, 8'h23);
		ss_n_in <= 1'b0;
		repeat (10) @(posedge clk_sys_in);
		rdc(A_CA, 8'h23);
		ss_n_in <= 1'b1;
		// The released select must clear the synchroniser before select-disable goes off
		repeat (4) @(posedge clk_sys_in);
		wr(A_CB, 8'h00);
		ss_n_in <= 1'b0;
		repeat (10) @(posedge clk_sys_in);
		ss_n_in <= 1'b1;
		rdc(A_CA, 8'h03);
		rdc(A_FL, 8'h80);
		chk({7'h0, irq_out}, 8'h01);
		wr(A_FL, 8'h80);
	endtask
	task automatic sbit(input logic b);
		tb_mosi <= b;
		repeat (8) @(posedge clk_sys_in);
		tb_sck <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		tb_sck <= 1'b0;
	endtask
	task automatic t_client;
		wr(A_CA, 8'h01);
		ss_n_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		chk({7'h0, miso_oe_out}, 8'h01);
		for (int i = 0; i < 4; i++) sbit(1'b1);
		ss_n_in <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		ss_n_in <= 1'b0;
		for (int i = 7; i >= 0; i--) sbit(1'(8'h3C >> i));
		repeat (8) @(posedge clk_sys_in);
		ss_n_in <= 1'b1;
		wirq(20);
		rdc(A_DT, 8'h3C);
		wr(A_FL, 8'h80);
	endtask
	initial begin
		{rst_n_in, hsel_in, hwrite_in, tb_sck, tb_mosi, plsb} = 6'h00;
		{ce_in, ss_n_in, psel_n} = 3'h7;
		{haddr_in, hwdata_in, htrans_in, pmode, ptx} = '0;
		num_errors = 0;
		checks = 0;
		repeat (12) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_regs;
		for (int m = 0; m < 4; m++) for (int l = 0; l < 2; l++) t_host(m[1:0], l[0]);
		t_coll;
		t_buf;
		t_div;
		t_ss;
		t_client;
		stop_test;
	end
	// Whole run is some five thousand cycles; this allows several times that
	initial begin
		#2000000;
		num_errors++;
		stop_test;
	end
endmodule
